// *** qgdsc_pkg.sv ***
// Constants, field layout and types shared by the quad gate driver serial control
// Functional notes
// RQ1: Frames are eight bits, shifted through one internal register while chip select is low.
// RQ2: Serial data input is sampled into the register on each serial clock rise.
// RQ3: Next output bit is shifted out on each serial clock fall during selection.
// RQ4: Gate is on when its serial bit or its parallel input is high.
// RQ5: Parallel input high turns its gate on without any serial transfer.
// RQ6: Command field picks one of eight deglitch times for all three fault kinds.
// RQ7: Command sleep bit puts the device into its low current sleep state.
// RQ8: Each channel reports a two bit code: normal, open, over-current, short.
// RQ9: Over-voltage lockout asserts the interrupt while every reported fault bit reads zero.
// RQ10: Shifted-in bits pass through to the serial output for daisy chains.
// RQ11: Chip select falling enables the interface and refreshes the fault interrupt.
// RQ12: With chip select high the register captures fault status for the next read.
// RQ13: Serial output is not driven while chip select is high.
// RQ14: Retry mode low: over-current or short latches the channel gate off.
// RQ15: Retry mode high: over-current or short starts low duty cycle auto retry.
// RQ16: Fault interrupt is active low open drain, asserted on any detected fault.
// RQ17: Open load is checked only while off; over-current and short only while on.
// RQ18: Reset low clears registers, fault bits, gates and the latched interrupt.
// RQ19: A latched interrupt is released only by chip select falling, or reset.
// RQ20: Command takes effect on chip select rising; frames move most significant bit first.
// RQ21: Command bit positions and fault code values are fixed here and documented.
package qgdsc_pkg;

    // Frame and channel geometry
    localparam int unsigned N_CH      = 4;
    localparam int unsigned FRAME_W   = 8;
    localparam int unsigned CODE_W    = 2;
    localparam int unsigned DGL_SEL_W = 3;

    // Command field positions (see RQ21)
    localparam int unsigned CMD_GATE_LSB  = 0;
    localparam int unsigned CMD_DGL_LSB   = 4;
    localparam int unsigned CMD_SLEEP_BIT = 7;
    localparam logic [7:0]  CMD_RESET     = 8'h00;

    // Fault codes, channel n sits at status bits [2n+1:2n] (see RQ21)
    localparam logic [1:0] CODE_NORMAL  = 2'h0;
    localparam logic [1:0] CODE_OPEN    = 2'h1;
    localparam logic [1:0] CODE_OVERCUR = 2'h2;
    localparam logic [1:0] CODE_SHORT   = 2'h3;

    // Timing: deglitch step per setting and auto-retry off time
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DGL_STEP_NS   = 10000;
    localparam int unsigned DGL_STEP_CYC  = (DGL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RETRY_OFF_NS  = 10000000;
    localparam int unsigned RETRY_OFF_CYC = (RETRY_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DGL_CNT_W     = 12;
    localparam int unsigned RETRY_CNT_W   = 20;

    // Per-channel gate state
    typedef enum logic [1:0] {
        CH_OFF,
        CH_ON,
        CH_LATCH,
        CH_RETRY
    } qgdsc_ch_state_t;

endpackage

// *** qgdsc_sync.sv ***
// Two flip-flop synchroniser for a vector of independent level inputs
`timescale 1ns/10ps
module qgdsc_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// *** qgdsc_top.sv ***
// Serial control, fault handling and gate logic of the quad gate driver
`timescale 1ns/10ps
module qgdsc_top #(
    parameter int unsigned RETRY_OFF_CYC = qgdsc_pkg::RETRY_OFF_CYC
) (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    // Serial link from the host
    input  wire logic                        i_cs_n,
    input  wire logic                        i_sclk,
    input  wire logic                        i_sdi,
    output logic                             o_sdo,
    output logic                             o_sdo_oe,
    // Parallel control and fault mode
    input  wire logic [qgdsc_pkg::N_CH-1:0]  i_parallel_gate_in,
    input  wire logic                        i_retry_mode_select,
    // Analog detector results
    input  wire logic [qgdsc_pkg::N_CH-1:0]  i_open_load_det,
    input  wire logic [qgdsc_pkg::N_CH-1:0]  i_over_current_det,
    input  wire logic [qgdsc_pkg::N_CH-1:0]  i_short_gnd_det,
    input  wire logic                        i_over_voltage,
    // Gate drive and analog controls
    output logic [qgdsc_pkg::N_CH-1:0]       o_gate_drive_out,
    output logic [qgdsc_pkg::DGL_SEL_W-1:0]  o_deglitch_sel,
    output logic                             o_sleep,
    // Open-drain fault interrupt
    output logic                             o_fault_irq_n_o,
    output logic                             o_fault_irq_n_oe
);
    import qgdsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    localparam int unsigned SYNC_W = 5 + 4 * N_CH;
    localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};

    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync_out;
    logic              cs_n_s;
    logic              sclk_s;
    logic              sdi_s;
    logic              retry_s;
    logic              ovlo_s;
    logic [N_CH-1:0]   par_s;
    logic [N_CH-1:0]   open_s;
    logic [N_CH-1:0]   oc_s;
    logic [N_CH-1:0]   short_s;

    // Every pin-side input except i_rst_n passes two flip-flops first
    // All these pins share one synchroniser, so they keep their relative timing
    assign async_in = {i_cs_n, i_sclk, i_sdi, i_retry_mode_select, i_over_voltage,
                       i_parallel_gate_in, i_open_load_det, i_over_current_det,
                       i_short_gnd_det};

    qgdsc_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (async_in),
        .o_sync  (sync_out)
    );

    // Split the synchronised vector
    assign {cs_n_s, sclk_s, sdi_s, retry_s, ovlo_s, par_s, open_s, oc_s, short_s} = sync_out;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on chip select and serial clock

    logic cs_n_prev_q;
    logic sclk_prev_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    // Previous synchronised levels
    // Reset values match the idle pin levels, so no false edge follows reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cs_n_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_n_prev_q <= cs_n_s;
            sclk_prev_q <= sclk_s;
        end
    end

    // Serial clock edges count only while selected; chip select edges always count
    assign cs_fall   = cs_n_prev_q & ~cs_n_s;
    assign cs_rise   = ~cs_n_prev_q & cs_n_s;
    assign sclk_rise = ~cs_n_s & ~sclk_prev_q & sclk_s;
    assign sclk_fall = ~cs_n_s & sclk_prev_q & ~sclk_s;

    ////////////////////////////////////////////////////////////////////////////
    // Shift register, fault capture and serial output

    logic [FRAME_W-1:0] sr_q;
    logic [FRAME_W-1:0] sr_d;
    logic               smp_q;
    logic               sdo_q;
    logic               sdo_d;
    logic               sdo_oe_q;
    logic [FRAME_W-1:0] status_frame;
    logic [CODE_W-1:0]  code_q [N_CH];

    // Status frame, forced to zero under over-voltage lockout
    generate
        for (genvar n = 0; n < N_CH; n++) begin : g_frame
            assign status_frame[CODE_W*n +: CODE_W] = ovlo_s ? CODE_NORMAL : code_q[n]; // see RQ9
        end
    endgenerate

    // Capture while deselected, shift on falling edges, MSB leaves first
    assign sr_d = cs_n_s    ? status_frame :                        // see RQ12
                  sclk_fall ? {sr_q[FRAME_W-2:0], smp_q} :          // see RQ1 RQ10
                  sr_q;
    assign sdo_d = cs_fall   ? sr_q[FRAME_W-1] :                    // see RQ20
                   sclk_fall ? sr_q[FRAME_W-2] :                    // see RQ3
                   sdo_q;

    // Rising edge samples the input bit
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            smp_q <= 1'b0;
        end else if (sclk_rise) begin
            smp_q <= sdi_s; // see RQ2
        end
    end

    // Shift register and output pin
    // Received bits leave on sdo a frame later, which lets devices be chained
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sr_q     <= '0;
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else begin
            sr_q     <= sr_d;
            sdo_q    <= sdo_d;
            sdo_oe_q <= ~cs_n_s; // see RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command register, loaded when chip select rises

    logic [N_CH-1:0]      gate_cmd_q;
    logic [DGL_SEL_W-1:0] dgl_sel_q;
    logic                 sleep_q;

    // Transfer the last eight received bits
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gate_cmd_q <= CMD_RESET[CMD_GATE_LSB +: N_CH];
            dgl_sel_q  <= CMD_RESET[CMD_DGL_LSB +: DGL_SEL_W];
            sleep_q    <= CMD_RESET[CMD_SLEEP_BIT];
        end else if (cs_rise) begin
            gate_cmd_q <= sr_q[CMD_GATE_LSB +: N_CH];      // see RQ20
            dgl_sel_q  <= sr_q[CMD_DGL_LSB +: DGL_SEL_W];  // see RQ6
            sleep_q    <= sr_q[CMD_SLEEP_BIT];             // see RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel detection, deglitch and gate state

    // Deglitch length in cycles for a setting
    function automatic logic [DGL_CNT_W-1:0] dgl_limit(input logic [DGL_SEL_W-1:0] sel);
        logic [DGL_CNT_W-1:0] steps;
        steps     = DGL_CNT_W'(sel) + DGL_CNT_W'(1);
        dgl_limit = DGL_CNT_W'(steps * DGL_CNT_W'(DGL_STEP_CYC));
    endfunction

    logic [DGL_CNT_W-1:0] dgl_lim;
    logic                 drive_en;
    logic [N_CH-1:0]      on_req;
    logic [N_CH-1:0]      gate_on_d;

    assign dgl_lim  = dgl_limit(dgl_sel_q);
    assign drive_en = ~sleep_q & ~ovlo_s;                           // see RQ7 RQ9
    assign on_req   = gate_cmd_q | par_s;                           // see RQ4 RQ5

    qgdsc_ch_state_t      st_q   [N_CH];
    qgdsc_ch_state_t      st_d   [N_CH];
    logic [CODE_W-1:0]    cond   [N_CH];
    logic [CODE_W-1:0]    prev_q [N_CH];
    logic [DGL_CNT_W-1:0] dcnt_q [N_CH];
    logic [RETRY_CNT_W-1:0] rcnt_q [N_CH];
    logic [N_CH-1:0]      fire;
    logic [N_CH-1:0]      hard;

    generate
        for (genvar n = 0; n < N_CH; n++) begin : g_ch
            logic is_on;

            // Detector qualification by the present gate state
            assign is_on   = (st_q[n] == CH_ON);
            assign cond[n] = (short_s[n] & is_on) ? CODE_SHORT :    // see RQ17
                             (oc_s[n] & is_on)    ? CODE_OVERCUR :  // see RQ17
                             (open_s[n] & ~is_on) ? CODE_OPEN :     // see RQ17
                             CODE_NORMAL;
            assign fire[n] = (cond[n] != CODE_NORMAL) && (cond[n] == prev_q[n])
                             && (dcnt_q[n] == dgl_lim);             // see RQ6
            assign hard[n] = fire[n] & cond[n][1];
            // A lasting open-load fault keeps fire high, since the counter saturates at the limit

            // Deglitch counter restarts whenever the condition changes
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    prev_q[n] <= CODE_NORMAL;
                    dcnt_q[n] <= '0;
                end else begin
                    prev_q[n] <= cond[n];
                    if (cond[n] == CODE_NORMAL || cond[n] != prev_q[n]) begin
                        dcnt_q[n] <= '0;
                    end else if (dcnt_q[n] != dgl_lim) begin
                        dcnt_q[n] <= dcnt_q[n] + 1'b1;
                    end
                end
            end

            // Reported code: a new fault wins over the chip select clear
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    code_q[n] <= CODE_NORMAL; // see RQ18
                end else if (fire[n]) begin
                    code_q[n] <= cond[n]; // see RQ8
                end else if (cs_fall) begin
                    code_q[n] <= CODE_NORMAL;
                end
            end

            // Gate state next value
            always_comb begin
                st_d[n] = st_q[n];
                unique case (st_q[n])
                    CH_OFF: begin
                        if (on_req[n] && drive_en) begin
                            st_d[n] = CH_ON;
                        end
                    end
                    CH_ON: begin
                        if (!(on_req[n] && drive_en)) begin
                            st_d[n] = CH_OFF;
                        end else if (hard[n]) begin
                            st_d[n] = retry_s ? CH_RETRY : CH_LATCH; // see RQ14 RQ15
                        end
                    end
                    CH_LATCH: begin
                        if (!on_req[n]) begin
                            st_d[n] = CH_OFF; // see RQ14
                        end
                    end
                    CH_RETRY: begin
                        if (!on_req[n] || rcnt_q[n] == '0) begin
                            st_d[n] = CH_OFF; // see RQ15
                        end
                    end
                endcase
            end
            assign gate_on_d[n] = (st_d[n] == CH_ON);

            // State and retry off-time counter
            // The channel stays off for RETRY_OFF_CYC + 1 cycles before it may switch on again
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    st_q[n]   <= CH_OFF;
                    rcnt_q[n] <= '0;
                end else begin
                    st_q[n] <= st_d[n];
                    if (st_q[n] != CH_RETRY && st_d[n] == CH_RETRY) begin
                        rcnt_q[n] <= RETRY_CNT_W'(RETRY_OFF_CYC - 1); // see RQ15
                    end else if (rcnt_q[n] != '0) begin
                        rcnt_q[n] <= rcnt_q[n] - 1'b1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Gate outputs and fault interrupt

    logic [N_CH-1:0] gate_q;
    logic            irq_q;
    logic            irq_set;

    // A qualified fault or lockout sets the interrupt; a code that only stands
    // does not, so the chip select clear can release it once the cause is gone
    assign irq_set = (|fire) | ovlo_s; // see RQ9 RQ16

    // Gate outputs follow the channel states
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gate_q <= '0; // see RQ18
        end else begin
            gate_q <= gate_on_d; // see RQ4 RQ5
        end
    end

    // Interrupt latch: set wins over the chip select release
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_q <= 1'b0; // see RQ18
        end else if (irq_set) begin
            irq_q <= 1'b1; // see RQ16
        end else if (cs_fall) begin
            irq_q <= 1'b0; // see RQ11 RQ19
        end
    end

    // Open drain: pull low while latched, never drive high
    // Only the enable moves, so the line can be shared with other devices
    logic irq_lvl_q;
    logic irq_oe_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_lvl_q <= 1'b0;
            irq_oe_q  <= 1'b0;
        end else begin
            irq_lvl_q <= 1'b0;
            irq_oe_q  <= irq_q; // see RQ16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output connections, all from flip-flops

    assign o_sdo            = sdo_q;
    assign o_sdo_oe         = sdo_oe_q;
    assign o_gate_drive_out = gate_q;
    assign o_deglitch_sel   = dgl_sel_q;
    assign o_sleep          = sleep_q;
    assign o_fault_irq_n_o  = irq_lvl_q;
    assign o_fault_irq_n_oe = irq_oe_q;

endmodule

// *** qgdsc_chk.sv ***
// Port relation checker for the gate driver serial control
`timescale 1ns/10ps
module qgdsc_chk #(
    parameter int unsigned RETRY_OFF_CYC = 50
) (
    // Clock and reset
    input wire logic                           i_clk,
    input wire logic                           i_rst_n,
    // Watched ports
    input wire logic                           i_cs_n,
    input wire logic [qgdsc_pkg::N_CH-1:0]     i_parallel_gate_in,
    input wire logic                           i_over_voltage,
    input wire logic                           o_sdo_oe,
    input wire logic [qgdsc_pkg::N_CH-1:0]     o_gate_drive_out,
    input wire logic [qgdsc_pkg::DGL_SEL_W-1:0] o_deglitch_sel,
    input wire logic                           o_sleep,
    input wire logic                           o_fault_irq_n_o,
    input wire logic                           o_fault_irq_n_oe
);
    import qgdsc_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////
    // Serial output enable follows chip select
    property p_sdo_hiz;
        i_cs_n [*7] |-> !o_sdo_oe;
    endproperty
    a_sdo_hiz: assert property (p_sdo_hiz) else $error("sdo driven while idle");
    property p_oe_on;
        !i_cs_n [*7] |-> o_sdo_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("sdo not enabled");
    ////////////////////////////////////////////////////////////////////
    // Gate control
    property p_par;
        $rose(i_parallel_gate_in[3]) && !o_sleep && !o_fault_irq_n_oe && !i_over_voltage
            |-> ##[1:6] o_gate_drive_out[3];
    endproperty
    a_par: assert property (p_par) else $error("parallel input ignored");
    property p_sleep;
        o_sleep [*3] |-> o_gate_drive_out == 4'h0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("gate on in sleep");
    ////////////////////////////////////////////////////////////////////
    // Fault line
    property p_ov;
        i_over_voltage [*6] |-> o_fault_irq_n_oe && o_gate_drive_out == 4'h0;
    endproperty
    a_ov: assert property (p_ov) else $error("lockout not flagged");
    property p_hold;
        i_cs_n [*8] ##0 o_fault_irq_n_oe |=> o_fault_irq_n_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("fault released early");
    property p_od;
        o_fault_irq_n_o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("fault line driven high");
    property p_rst;
        disable iff (1'b0) !i_rst_n |=> o_gate_drive_out == 4'h0 && !o_sleep && !o_sdo_oe
            && !o_fault_irq_n_oe && o_deglitch_sel == 3'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind qgdsc_top qgdsc_chk #(.RETRY_OFF_CYC(RETRY_OFF_CYC)) chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
    .i_parallel_gate_in(i_parallel_gate_in), .i_over_voltage(i_over_voltage),
    .o_sdo_oe(o_sdo_oe), .o_gate_drive_out(o_gate_drive_out),
    .o_deglitch_sel(o_deglitch_sel), .o_sleep(o_sleep),
    .o_fault_irq_n_o(o_fault_irq_n_o), .o_fault_irq_n_oe(o_fault_irq_n_oe)
);

// *** qgdsc_host.sv ***
// Host serial port model sending frames most significant bit first
`timescale 1ns/10ps
module qgdsc_host (
    // Clock and frame request
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic [4:0]  i_nbits,
    input  wire logic [15:0] i_tx,
    input  wire logic        i_sdo,
    // Serial pins and result
    output logic             o_cs_n,
    output logic             o_sclk,
    output logic             o_sdi,
    output logic [15:0]      o_rx,
    output logic             o_busy
);
    int i;
    // One frame per start; serial clock stands low outside frames
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
        o_rx   = 16'h0000;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_start) begin
                o_busy <= 1'b1;
                o_cs_n <= 1'b0;
                repeat (8) @(posedge i_clk);
                for (i = int'(i_nbits) - 1; i >= 0; i--) begin
                    o_sdi <= i_tx[i];
                    repeat (5) @(posedge i_clk);
                    o_sclk <= 1'b1;
                    o_rx   <= {o_rx[14:0], i_sdo};
                    repeat (3) @(posedge i_clk);
                    o_sclk <= 1'b0;
                end
                repeat (5) @(posedge i_clk);
                o_cs_n <= 1'b1;
                o_sdi  <= ~o_sdi; // Data no longer held after the frame
                repeat (8) @(posedge i_clk);
                o_busy <= 1'b0;
            end
        end
    end
endmodule

// *** tb_top.sv ***
// Self-checking bench of the gate driver serial control
`timescale 1ns/10ps
module tb_top;
    import qgdsc_pkg::*;
    localparam int RCYC = 50;
    // Stimulus and observed signals
    logic        i_clk = 1'b0, rst_n = 1'b0, retry = 1'b0, ov = 1'b0;
    logic [3:0]  par = 4'h0, ol = 4'h0, oc = 4'h0, sg = 4'h0, gate;
    logic        h_start = 1'b0, h_busy, cs_n, sclk, sdi, sdo, sdo_oe, sdo_last = 1'b0;
    logic        irq_o, irq_oe, sleep;
    logic [2:0]  dgl;
    logic [4:0]  h_nb = 5'h08;
    logic [15:0] h_tx = 16'h0000, h_rx, rx;
    wire         sdo_w, flt_w;
    int          n_mismatch = 0, n_checks = 0;
    // Clock and wire levels (released sdo shows the inverse, fault line pulled up)
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (sdo_oe) sdo_last <= sdo;
    assign sdo_w = sdo_oe ? sdo : ~sdo_last;
    assign flt_w = irq_oe ? irq_o : 1'b1;
    ////////////////////////////////////////////////////////////////////
    // Design and host model
    qgdsc_top #(.RETRY_OFF_CYC(RCYC)) dut_u (.i_clk(i_clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_parallel_gate_in(par),
        .i_retry_mode_select(retry), .i_open_load_det(ol), .i_over_current_det(oc),
        .i_short_gnd_det(sg), .i_over_voltage(ov), .o_gate_drive_out(gate),
        .o_deglitch_sel(dgl), .o_sleep(sleep), .o_fault_irq_n_o(irq_o),
        .o_fault_irq_n_oe(irq_oe));
    qgdsc_host host_u (.i_clk(i_clk), .i_start(h_start), .i_nbits(h_nb), .i_tx(h_tx),
        .i_sdo(sdo_w), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .o_rx(h_rx),
        .o_busy(h_busy));
    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic frame(input logic [15:0] tx, input logic [4:0] nb);
        int k;
        h_tx    <= tx;
        h_nb    <= nb;
        h_start <= 1'b1;
        @(posedge i_clk);
        h_start <= 1'b0;
        @(posedge i_clk);
        for (k = 0; k < 300 && h_busy; k++) begin
            @(posedge i_clk);
        end
        if (h_busy) begin
            n_mismatch++;
            complete_run();
        end
        rx = h_rx;
    endtask
    task automatic wait_gate(input int ch, input logic lvl, input int lim);
        int k;
        for (k = 0; k < lim && gate[ch] !== lvl; k++) begin
            @(posedge i_clk);
        end
        if (gate[ch] !== lvl) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_cmd();
        for (int s = 0; s < 8; s++) begin
            frame({8'h00, 1'b0, 3'(s), 4'(s + 1)}, 5'h08);
            check("dgl", 16'(dgl), 16'(s));
            check("gate", 16'(gate), 16'(s + 1));
        end
    endtask
    task automatic s_par();
        frame(16'h0000, 5'h08);
        par <= 4'h8;
        cyc(6);
        check("par on", 16'(gate), 16'h0008);
        frame(16'h0001, 5'h08);
        check("or", 16'(gate), 16'h0009);
        par <= 4'h0;
        cyc(6);
        check("serial only", 16'(gate), 16'h0001);
        par <= 4'h2;
        frame(16'h0080, 5'h08);
        check("sleep", 16'(sleep), 16'h0001);
        check("sleep gate", 16'(gate), 16'h0000);
        frame(16'h0000, 5'h08);
        check("wake gate", 16'(gate), 16'h0002);
        par <= 4'h0;
    endtask
    task automatic s_open();
        frame(16'h0010, 5'h08);
        ol <= 4'h2;
        cyc(300);
        check("flt early", 16'(flt_w), 16'h0001);
        cyc(200);
        check("flt set", 16'(flt_w), 16'h0000);
        ol <= 4'h0;
        cyc(20);
        check("flt held", 16'(flt_w), 16'h0000);
        frame(16'ha510, 5'h10);
        check("chain rx", rx, 16'h04a5);
        check("flt clr", 16'(flt_w), 16'h0001);
        frame(16'h0011, 5'h08);
        ol <= 4'h1;
        cyc(500);
        check("open while on", 16'(flt_w), 16'h0001);
        ol <= 4'h0;
    endtask
    task automatic s_latch();
        frame(16'h0001, 5'h08);
        oc <= 4'h1;
        wait_gate(0, 1'b0, 300);
        oc <= 4'h0;
        cyc(20);
        check("latched", 16'(gate), 16'h0000);
        frame(16'h0000, 5'h08);
        check("oc code", rx & 16'h00ff, 16'h0002);
        frame(16'h0001, 5'h08);
        check("relatch", 16'(gate), 16'h0001);
        oc <= 4'h1;
        cyc(300);
        oc <= 4'h0;
        rst_n <= 1'b0;
        cyc(4);
        check("rst flt", 16'(flt_w), 16'h0001);
        rst_n <= 1'b1;
        cyc(2);
    endtask
    task automatic s_retry();
        retry <= 1'b1;
        par <= 4'h4;
        sg <= 4'h4;
        wait_gate(2, 1'b1, 10);
        wait_gate(2, 1'b0, 300);
        sg <= 4'h0;
        cyc(RCYC - 10);
        check("retry off", 16'(gate[2]), 16'h0000);
        wait_gate(2, 1'b1, 30);
        frame(16'h0000, 5'h08);
        check("short code", rx & 16'h00ff, 16'h0030);
        par <= 4'h0;
        retry <= 1'b0;
        ov <= 1'b1;
        cyc(10);
        frame(16'h0000, 5'h08);
        check("ov rx", rx & 16'h00ff, 16'h0000);
        check("ov flt", 16'(flt_w), 16'h0000);
        ov <= 1'b0;
        cyc(5);
        frame(16'h0000, 5'h08);
        check("ov clr", 16'(flt_w), 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        cyc(16);
        check("rst gate", 16'(gate), 16'h0000);
        rst_n <= 1'b1;
        cyc(2);
        s_cmd();
        s_par();
        s_open();
        s_latch();
        s_retry();
        complete_run();
    end
endmodule
